/* File: hw/flash_program_control_pkg.sv */
package flash_program_control_pkg;
    localparam logic [7:0] FLASH_CTRL_ADDR = 8'hd1;
    localparam logic [7:0] FLASH_CTRL_RESET = 8'h00;
    localparam int KEY_MSB = 7;
    localparam int KEY_LSB = 4;
    localparam int LATCH_SEL_BIT = 3;
    localparam int SPACE_MSB = 2;
    localparam int SPACE_LSB = 1;
    localparam int BUSY_BIT = 0;
    localparam logic [3:0] KEY_FIRST = 4'h5;
    localparam logic [3:0] KEY_SECOND = 4'ha;
    localparam int CFG_DOUBLE_SPEED_BIT = 7;
    localparam int CFG_BOOT_JUMP_BIT = 6;
    localparam int CFG_LOCK_MSB = 2;
    localparam logic [7:0] CFG_RESET = 8'hff;
    localparam logic [15:0] USER_START_ADDR = 16'h0000;
    localparam logic [15:0] BOOT_START_ADDR = 16'hf800;
    localparam logic [15:0] EXTRA_ROW_BASE = 16'hff80;
    localparam int LATCH_DEPTH = 128;
    localparam int LATCH_AW = 7;
    localparam logic [1:0] SPACE_USER = 2'b00;
    localparam logic [1:0] SPACE_EXTRA_ROW = 2'b01;
    localparam logic [1:0] SPACE_CONFIG = 2'b10;
    localparam logic [1:0] SPACE_LATCH_RESET = 2'b11;
    localparam int PROG_TIME_US = 10;
    localparam int CLK_MHZ = 50;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam logic [2:0] LOCK_EXT_READ_OK = 3'b111;
    typedef enum logic [1:0] {
        EXEC_USER = 2'b00,
        EXEC_BOOT = 2'b01,
        EXEC_EXTERNAL = 2'b10
    } exec_src_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_KEYED = 3'b010,
        ST_PROGRAM = 3'b100
    } prog_state_t;
endpackage

/* File: hw/column_latch_mem.sv */
module column_latch_mem
    import flash_program_control_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic wr_en_i,
    input wire logic [LATCH_AW-1:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [LATCH_AW-1:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic [LATCH_DEPTH-1:0] loaded_o
);
    logic [7:0] mem [LATCH_DEPTH];
    logic [LATCH_DEPTH-1:0] loaded;

    // Contents are kept until reloaded; only the loaded map is cleared.
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loaded <= '0;
        end else if (clear_i) begin
            loaded <= '0;
        end else if (wr_en_i) begin
            loaded[wr_addr_i] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

    assign loaded_o = loaded;
endmodule

/* File: hw/flash_program_control.sv */
module flash_program_control
    import flash_program_control_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic xdata_wr_i,
    input wire logic [15:0] xdata_addr_i,
    input wire logic [7:0] xdata_wdata_i,
    output logic xram_wr_o,
    input wire logic [1:0] exec_src_i,
    input wire logic code_rd_i,
    input wire logic code_rd_boot_i,
    output logic code_rd_allow_o,
    output logic [1:0] code_space_o,
    input wire logic [7:0] cfg_byte_i,
    input wire logic cfg_prog_i,
    input wire logic [7:0] cfg_prog_data_i,
    output logic double_speed_cfg_o,
    output logic boot_area_map_en_o,
    output logic [15:0] start_addr_o,
    output logic [2:0] lock_level_bits_o,
    output logic launch_sequence_error_o,
    output logic array_wr_o,
    output logic [1:0] array_space_o,
    output logic [15:0] array_addr_o,
    output logic [7:0] array_data_o
);
    // ************************************************************
    // Register access and configuration byte
    // ************************************************************
    logic [3:0] key;
    logic latch_sel;
    logic [1:0] space;
    logic busy;
    logic [7:0] cfg;
    logic cfg_loaded;
    logic launch_sequence_error;
    prog_state_t state;
    logic [8:0] page;
    logic [LATCH_AW-1:0] idx;
    logic [$clog2(PROG_CYCLES+1)-1:0] cnt;
    logic ctrl_wr;
    logic [3:0] wkey;
    logic launch_ok;
    logic latch_wr;
    logic latch_clear;
    logic [7:0] latch_rd;
    logic [LATCH_DEPTH-1:0] latch_loaded;
    logic [7:0] cfg_sync1;
    logic [7:0] cfg_sync2;
    logic cfg_prog_sync1;
    logic cfg_prog_sync2;
    logic [7:0] cfg_data_sync1;
    logic [7:0] cfg_data_sync2;
    logic [1:0] warm;

    assign ctrl_wr = sfr_wr_i && (sfr_addr_i == FLASH_CTRL_ADDR);
    assign wkey = sfr_wdata_i[KEY_MSB:KEY_LSB];

    function automatic logic from_boot(input logic [1:0] src);
        from_boot = (src == EXEC_BOOT);
    endfunction

    // Strap pins pass two flops before the reset capture reads them.
    // The programmer's data byte rides the same two stages as its strobe,
    // so both reach the capture logic on the same edge.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_sync1 <= CFG_RESET;
            cfg_sync2 <= CFG_RESET;
            cfg_prog_sync1 <= 1'b0;
            cfg_prog_sync2 <= 1'b0;
            cfg_data_sync1 <= 8'h00;
            cfg_data_sync2 <= 8'h00;
        end else begin
            cfg_sync1 <= cfg_byte_i;
            cfg_sync2 <= cfg_sync1;
            cfg_prog_sync1 <= cfg_prog_i;
            cfg_prog_sync2 <= cfg_prog_sync1;
            cfg_data_sync1 <= cfg_prog_data_i;
            cfg_data_sync2 <= cfg_data_sync1;
        end
    end

    // The second stage still holds its reset value on the first edge after
    // release, so the capture waits until both stages have filled.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            warm <= 2'b00;
        end else begin
            warm <= {warm[0], 1'b1};
        end
    end

    // The byte is sampled once after reset release; software programming of
    // the config space may only touch the upper nibble, so locks stay put.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg <= CFG_RESET;
            cfg_loaded <= 1'b0;
        end else if (!cfg_loaded) begin
            if (warm == 2'b11) begin
                cfg <= cfg_sync2;
                cfg_loaded <= 1'b1;
            end
        end else if (cfg_prog_sync2) begin
            cfg <= cfg_data_sync2;
        end else if (array_wr_o && array_space_o == SPACE_CONFIG) begin
            cfg <= {array_data_o[7:4], cfg[3:0]};
        end
    end

    assign double_speed_cfg_o = ~cfg[CFG_DOUBLE_SPEED_BIT];
    assign boot_area_map_en_o = ~cfg[CFG_BOOT_JUMP_BIT];
    assign start_addr_o = cfg[CFG_BOOT_JUMP_BIT] ? USER_START_ADDR : BOOT_START_ADDR;
    assign lock_level_bits_o = cfg[CFG_LOCK_MSB:0];

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key <= FLASH_CTRL_RESET[KEY_MSB:KEY_LSB];
            latch_sel <= FLASH_CTRL_RESET[LATCH_SEL_BIT];
            space <= FLASH_CTRL_RESET[SPACE_MSB:SPACE_LSB];
        end else if (ctrl_wr) begin
            key <= wkey;
            latch_sel <= sfr_wdata_i[LATCH_SEL_BIT];
            space <= sfr_wdata_i[SPACE_MSB:SPACE_LSB];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i && sfr_addr_i == FLASH_CTRL_ADDR) begin
            sfr_rdata_o <= {key, latch_sel, space, busy};
        end else begin
            sfr_rdata_o <= 8'h00;
        end
    end

    // ************************************************************
    // Column latch load and data-space steering
    // ************************************************************
    assign latch_wr = xdata_wr_i && latch_sel && !busy && (exec_src_i != EXEC_EXTERNAL);
    assign xram_wr_o = xdata_wr_i && !latch_sel;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            page <= 9'h000;
        end else if (latch_wr) begin
            page <= xdata_addr_i[15:7];
        end
    end

    // Latch contents have no read path to software.
    column_latch_mem u_latch (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(latch_clear),
        .wr_en_i(latch_wr),
        .wr_addr_i(xdata_addr_i[LATCH_AW-1:0]),
        .wr_data_i(xdata_wdata_i),
        .rd_addr_i(idx),
        .rd_data_o(latch_rd),
        .loaded_o(latch_loaded)
    );

    // ************************************************************
    // Launch sequence and programming
    // ************************************************************
    // User array needs boot execution; boot flash pages are not blocked from the write path.
    assign launch_ok = (state == ST_KEYED) && ctrl_wr && (wkey == KEY_SECOND) && !busy
        && from_boot(exec_src_i);
    // A latch reset request uses the launch pair but never raises busy.
    assign latch_clear = launch_ok && sfr_wdata_i[SPACE_MSB:SPACE_LSB] == SPACE_LATCH_RESET;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (ctrl_wr && wkey == KEY_FIRST && !busy) begin
                        state <= ST_KEYED;
                    end
                end
                ST_KEYED: begin
                    if (launch_ok && !latch_clear) begin
                        state <= ST_PROGRAM;
                    end else if (ctrl_wr) begin
                        state <= ST_IDLE;
                    end
                end
                ST_PROGRAM: begin
                    if (cnt == '0 && idx == LATCH_AW'(LATCH_DEPTH - 1)) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Busy follows the program state only; writes never touch it.
    assign busy = (state == ST_PROGRAM);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            launch_sequence_error <= 1'b0;
        end else if (ctrl_wr && state == ST_KEYED && wkey != KEY_SECOND) begin
            launch_sequence_error <= 1'b1;
        end else if (ctrl_wr && wkey == KEY_SECOND && state != ST_KEYED) begin
            launch_sequence_error <= 1'b1;
        end else if (launch_ok) begin
            launch_sequence_error <= 1'b0;
        end
    end
    assign launch_sequence_error_o = launch_sequence_error;

    // Each latch byte gets a fixed write slot; unloaded bytes are skipped.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idx <= '0;
            cnt <= '0;
        end else if (launch_ok) begin
            idx <= '0;
            cnt <= ($bits(cnt))'(PROG_CYCLES / LATCH_DEPTH);
        end else if (state == ST_PROGRAM) begin
            if (cnt != '0) begin
                cnt <= cnt - 1'b1;
            end else if (idx != LATCH_AW'(LATCH_DEPTH - 1)) begin
                idx <= idx + 1'b1;
                cnt <= ($bits(cnt))'(PROG_CYCLES / LATCH_DEPTH);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            array_wr_o <= 1'b0;
            array_space_o <= SPACE_USER;
            array_addr_o <= 16'h0000;
            array_data_o <= 8'h00;
        end else begin
            array_wr_o <= (state == ST_PROGRAM) && (cnt == 1) && latch_loaded[idx];
            array_space_o <= space;
            array_data_o <= latch_rd;
            case (space)
                SPACE_EXTRA_ROW: array_addr_o <= EXTRA_ROW_BASE | {9'h000, idx};
                SPACE_CONFIG: array_addr_o <= 16'h0000;
                default: array_addr_o <= {page, idx};
            endcase
        end
    end

    // ************************************************************
    // Read access rights
    // ************************************************************
    // External code reads only while every lock level bit is left open.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_rd_allow_o <= 1'b0;
        end else begin
            case (exec_src_i)
                EXEC_BOOT: code_rd_allow_o <= code_rd_i;
                EXEC_USER: code_rd_allow_o <= code_rd_i && !code_rd_boot_i;
                default: code_rd_allow_o <= code_rd_i && !code_rd_boot_i
                    && cfg[CFG_LOCK_MSB:0] == LOCK_EXT_READ_OK;
            endcase
        end
    end
    assign code_space_o = space;
endmodule

/* File: dv/flash_program_control_asserts.sv */
module flash_program_control_asserts
    import flash_program_control_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic xdata_wr_i,
    input wire logic xram_wr_o,
    input wire logic [1:0] exec_src_i,
    input wire logic code_rd_i,
    input wire logic code_rd_boot_i,
    input wire logic code_rd_allow_o,
    input wire logic [1:0] code_space_o,
    input wire logic cfg_prog_i,
    input wire logic boot_area_map_en_o,
    input wire logic [15:0] start_addr_o,
    input wire logic [2:0] lock_level_bits_o,
    input wire logic launch_sequence_error_o
);
    // ****************************************
    // Shadow of the software-written control bits
    // ****************************************
    logic [7:0] ctl;
    logic keyed;
    logic [2:0] age;
    logic [1:0] prog_hist;
    logic ctl_wr;
    logic [3:0] key;
    assign ctl_wr = sfr_wr_i && sfr_addr_i == FLASH_CTRL_ADDR;
    assign key = sfr_wdata_i[KEY_MSB:KEY_LSB];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl <= 8'h00;
            keyed <= 1'b0;
            age <= 3'h0;
            prog_hist <= 2'b00;
        end else begin
            if (ctl_wr) begin
                ctl <= sfr_wdata_i;
                keyed <= key == KEY_FIRST;
            end
            // The programmer strobe crosses two flops, so its effect lands two edges late.
            prog_hist <= {prog_hist[0], cfg_prog_i};
            // The strap is captured a few edges after release, so lock checks wait for it.
            if (age != 3'h7) begin
                age <= age + 3'h1;
            end
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_rd_other; sfr_rd_i && sfr_addr_i != FLASH_CTRL_ADDR |=> sfr_rdata_o == 8'h00; endproperty
    a_rd_other: assert property (p_rd_other) else $error("stray read data");
    property p_start; start_addr_o == (boot_area_map_en_o ? BOOT_START_ADDR : USER_START_ADDR); endproperty
    a_start: assert property (p_start) else $error("start address mismatch");
    property p_lock; age == 3'h7 && !cfg_prog_i && prog_hist == 2'b00 |=> $stable(lock_level_bits_o); endproperty
    a_lock: assert property (p_lock) else $error("lock bits moved");
    property p_user_rd; code_rd_i && code_rd_boot_i && exec_src_i == EXEC_USER |=> !code_rd_allow_o; endproperty
    a_user_rd: assert property (p_user_rd) else $error("boot read from user allowed");
    property p_boot_rd; code_rd_i && exec_src_i == EXEC_BOOT |=> code_rd_allow_o; endproperty
    a_boot_rd: assert property (p_boot_rd) else $error("boot code read refused");
    property p_ext_rd;
        code_rd_i && !code_rd_boot_i && exec_src_i == EXEC_EXTERNAL
            |=> code_rd_allow_o == ($past(lock_level_bits_o) == LOCK_EXT_READ_OK);
    endproperty
    a_ext_rd: assert property (p_ext_rd) else $error("external read rights wrong");
    property p_seq_err; ctl_wr && (keyed ? key != KEY_FIRST && key != KEY_SECOND : key == KEY_SECOND)
        |=> launch_sequence_error_o; endproperty
    a_seq_err: assert property (p_seq_err) else $error("bad key not flagged");
    property p_xram; xdata_wr_i |-> xram_wr_o == !ctl[LATCH_SEL_BIT]; endproperty
    a_xram: assert property (p_xram) else $error("data write steered wrongly");
    property p_space; code_space_o == ctl[SPACE_MSB:SPACE_LSB]; endproperty
    a_space: assert property (p_space) else $error("code space select wrong");
endmodule

bind flash_program_control flash_program_control_asserts chk_u (.clk_i, .rst_n_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .xdata_wr_i, .xram_wr_o, .exec_src_i, .code_rd_i,
    .code_rd_boot_i, .code_rd_allow_o, .code_space_o, .cfg_prog_i, .boot_area_map_en_o, .start_addr_o,
    .lock_level_bits_o, .launch_sequence_error_o);

/* File: dv/cpu_core_model.sv */
module cpu_core_model
    import flash_program_control_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic sfr_wr_o,
    output logic sfr_rd_o,
    output logic [7:0] sfr_addr_o,
    output logic [7:0] sfr_wdata_o,
    output logic xdata_wr_o,
    output logic [15:0] xdata_addr_o,
    output logic [7:0] xdata_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Core-side register and data-space cycles
    // ****************************************
    initial begin
        sfr_wr_o = 1'b0;
        sfr_rd_o = 1'b0;
        sfr_addr_o = 8'h00;
        sfr_wdata_o = 8'h00;
        xdata_wr_o = 1'b0;
        xdata_addr_o = 16'h0000;
        xdata_wdata_o = 8'h00;
    end
    // Released data is inverted so a stale value is never mistaken for a fresh one.
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        sfr_wr_o = 1'b1;
        sfr_addr_o = a;
        sfr_wdata_o = d;
        @(posedge clk_i);
        #1;
        sfr_wr_o = 1'b0;
        sfr_wdata_o = ~d;
    endtask
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        sfr_rd_o = 1'b1;
        sfr_addr_o = a;
        @(posedge clk_i);
        #1;
        sfr_rd_o = 1'b0;
        d = rdata_i;
    endtask
    task automatic xdata_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        xdata_wr_o = 1'b1;
        xdata_addr_o = a;
        xdata_wdata_o = d;
        @(posedge clk_i);
        #1;
        xdata_wr_o = 1'b0;
        xdata_wdata_o = ~d;
    endtask
    task automatic launch(input logic [3:0] second, input logic [3:0] low);
        sfr_write(FLASH_CTRL_ADDR, {KEY_FIRST, low});
        sfr_write(FLASH_CTRL_ADDR, {second, low});
    endtask
endmodule

/* File: dv/test_flash_program_control.sv */
module test_flash_program_control
    import flash_program_control_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, xdata_wr_i, xram_wr_o, code_rd_i, code_rd_boot_i;
    logic code_rd_allow_o, cfg_prog_i, double_speed_cfg_o, boot_area_map_en_o, err_o, array_wr_o;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, xdata_wdata_i, cfg_byte_i, cfg_prog_data_i, d;
    logic [7:0] array_data_o, first_data;
    logic [15:0] xdata_addr_i, start_addr_o, array_addr_o, first_addr;
    logic [1:0] exec_src_i, array_space_o;
    logic [2:0] lock_level_bits_o;
    int err_total = 0;
    int tests_run = 0;
    int wr_cnt = 0;
    flash_program_control dut_u (.clk_i, .rst_n_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i,
        .sfr_rdata_o, .xdata_wr_i, .xdata_addr_i, .xdata_wdata_i, .xram_wr_o, .exec_src_i, .code_rd_i,
        .code_rd_boot_i, .code_rd_allow_o, .code_space_o(), .cfg_byte_i, .cfg_prog_i, .cfg_prog_data_i,
        .double_speed_cfg_o, .boot_area_map_en_o, .start_addr_o, .lock_level_bits_o,
        .launch_sequence_error_o(err_o), .array_wr_o, .array_space_o, .array_addr_o, .array_data_o);
    cpu_core_model cpu (.clk_i, .rdata_i(sfr_rdata_o), .sfr_wr_o(sfr_wr_i), .sfr_rd_o(sfr_rd_i),
        .sfr_addr_o(sfr_addr_i), .sfr_wdata_o(sfr_wdata_i), .xdata_wr_o(xdata_wr_i),
        .xdata_addr_o(xdata_addr_i), .xdata_wdata_o(xdata_wdata_i));
    // ****************************************
    // Clock, monitors and shared tasks
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (array_wr_o === 1'b1) begin
            if (wr_cnt == 0) begin
                first_addr <= array_addr_o;
                first_data <= array_data_o;
            end
            wr_cnt <= wr_cnt + 1;
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        err_total++;
        conclude();
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_reset(input logic [7:0] cfg);
        rst_n_i = 1'b0;
        cfg_byte_i = cfg;
        repeat (16) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 400; n++) begin
            cpu.sfr_read(FLASH_CTRL_ADDR, d);
            if (d[BUSY_BIT] === 1'b0) begin
                return;
            end
        end
        err_total++;
        conclude();
    endtask
    task automatic code_read(input logic [1:0] s, input logic b, input logic e);
        @(posedge clk_i);
        #1;
        exec_src_i = s;
        code_rd_i = 1'b1;
        code_rd_boot_i = b;
        @(posedge clk_i);
        #1;
        code_rd_i = 1'b0;
        check(code_rd_allow_o, e);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        exec_src_i = EXEC_BOOT;
        code_rd_i = 1'b0;
        code_rd_boot_i = 1'b0;
        cfg_prog_i = 1'b0;
        cfg_prog_data_i = 8'h00;
        do_reset(8'h3f);
        cpu.sfr_read(FLASH_CTRL_ADDR, d);
        check(d, FLASH_CTRL_RESET);
        check(double_speed_cfg_o, 1'b1);
        check(start_addr_o, BOOT_START_ADDR);
        cpu.sfr_read(8'hd0, d);
        check(d, 8'h00);
        cpu.sfr_write(FLASH_CTRL_ADDR, 8'h09);
        cpu.sfr_read(FLASH_CTRL_ADDR, d);
        check(d, 8'h08);
        for (int i = 0; i < 4; i++) begin
            cpu.xdata_write(16'h1200 + 16'(i), 8'h30 + 8'(i));
        end
        exec_src_i = EXEC_USER;
        cpu.launch(KEY_SECOND, 4'h0);
        cpu.sfr_read(FLASH_CTRL_ADDR, d);
        check(d[BUSY_BIT], 1'b0);
        cpu.xdata_write(16'h0040, 8'h5a);
        exec_src_i = EXEC_BOOT;
        cpu.launch(4'h3, 4'h0);
        check(err_o, 1'b1);
        cpu.sfr_read(FLASH_CTRL_ADDR, d);
        check(d[BUSY_BIT], 1'b0);
        for (int r = 0; r < 2; r++) begin
            wr_cnt = 0;
            cpu.launch(KEY_SECOND, 4'h0);
            cpu.sfr_read(FLASH_CTRL_ADDR, d);
            check(d[BUSY_BIT], 1'b1);
            check(err_o, 1'b0);
            wait_idle();
            check(wr_cnt, 4);
            check(first_addr, 16'h1200);
            check(first_data, 8'h30);
        end
        wr_cnt = 0;
        cpu.launch(KEY_SECOND, {1'b0, SPACE_EXTRA_ROW, 1'b0});
        wait_idle();
        check(wr_cnt, 4);
        check(first_addr, EXTRA_ROW_BASE);
        check(array_space_o, SPACE_EXTRA_ROW);
        cpu.launch(KEY_SECOND, {1'b0, SPACE_LATCH_RESET, 1'b0});
        wr_cnt = 0;
        cpu.launch(KEY_SECOND, 4'h0);
        wait_idle();
        check(wr_cnt, 0);
        for (int s = 0; s < 3; s++) begin
            for (int b = 0; b < 2; b++) begin
                code_read(2'(s), 1'(b), s == 1 || b == 0);
            end
        end
        @(posedge clk_i);
        #1;
        cfg_prog_i = 1'b1;
        cfg_prog_data_i = 8'hf8;
        @(posedge clk_i);
        #1;
        cfg_prog_i = 1'b0;
        // The strobe crosses two flops, so the new locks land two edges later.
        repeat (2) @(posedge clk_i);
        #1;
        check(lock_level_bits_o, 3'b000);
        code_read(EXEC_EXTERNAL, 1'b0, 1'b0);
        do_reset(8'hff);
        check(start_addr_o, USER_START_ADDR);
        check(double_speed_cfg_o, 1'b0);
        conclude();
    end
endmodule
